// ===== logic/trig_defines.svh
// offsets, field layouts, error codes and timing counts of the trigger sequencer
// assumes a 100 MHz system clock and a 32-bit classic wishbone slave
`ifndef TRIG_DEFINES_SVH
`define TRIG_DEFINES_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_FUNC_A 8'h04
`define OFS_FUNC_B 8'h08
`define OFS_FILTER 8'h0C
`define OFS_CHANNEL 8'h10
`define OFS_STATUS 8'h14
`define OFS_EDIT 8'h18

// control fields
`define CTL_SEL_B 0
`define CTL_SEQ 1
`define CTL_EXTQ 2
`define CTL_SLOPE 3
`define CTL_GATE 4
`define CTL_VIEW 5
`define CTL_ALT 6
`define CTL_W 7

// term width and columns
`define TERM_W 3
`define FUNC_W 24

// status error codes
`define ERR_NONE 4'h0
`define ERR_OR_FULL 4'h7
`define ERR_EDGE_ON 4'hA
`define ERR_EXTCLK_ON 4'hB

// chop timing: one megahertz switching
`define CHOP_NS 1000
`define CLK_NS 10
`define CHOP_CYC (`CHOP_NS / `CLK_NS)

`endif

// ===== logic/trig_pkg.sv
// types shared by the trigger sequencer files
// assumes trig_defines.svh is compiled alongside
package trig_pkg;
	typedef enum logic [2:0] {
		TERM_IGNORE = 3'h0,
		TERM_HIGH = 3'h1,
		TERM_LOW = 3'h2,
		TERM_RISE = 3'h3,
		TERM_FALL = 3'h4
	} term_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ARMED = 3'b010,
		SEQ_FIRED = 3'b100
	} seq_state_t;
endpackage : trig_pkg

// ===== logic/word_recognizer.sv
// one stored trigger function: two four-term and-columns ored together
// assumes channel levels and edge pulses already synchronised to clk
`include "trig_defines.svh"

module word_recognizer #(
	parameter int CHANNELS = 4
) (
	// programmed terms, column 1 in the upper half
	input wire logic [`FUNC_W-1:0] terms,
	// synchronised channel view
	input wire logic [CHANNELS-1:0] level,
	input wire logic [CHANNELS-1:0] rise,
	input wire logic [CHANNELS-1:0] fall,
	// results
	output logic hit,
	output logic has_edge
);
	import trig_pkg::*;

	logic [1:0][CHANNELS-1:0] term_ok;
	logic [1:0][CHANNELS-1:0] term_used;
	logic [1:0][CHANNELS-1:0] term_edge;

	for (genvar c = 0; c < 2; c++) begin : g_col
		for (genvar i = 0; i < CHANNELS; i++) begin : g_term
			logic [2:0] t;
			assign t = terms[(c*CHANNELS+i)*`TERM_W +: `TERM_W];
			always_comb begin
				case (t)
					TERM_HIGH: term_ok[c][i] = level[i];
					TERM_LOW: term_ok[c][i] = !level[i];
					TERM_RISE: term_ok[c][i] = rise[i];
					TERM_FALL: term_ok[c][i] = fall[i];
					default: term_ok[c][i] = 1'b1;
				endcase
			end
			assign term_used[c][i] = (t != TERM_IGNORE);
			assign term_edge[c][i] = (t == TERM_RISE) || (t == TERM_FALL);
		end
	end

	// an all-ignore column would make the or always true
	assign hit = (|term_used[0] && &term_ok[0]) || (|term_used[1] && &term_ok[1]);
	assign has_edge = |term_edge;
endmodule : word_recognizer

// ===== logic/trig_sequencer.sv
// logic word trigger sequencer with a classic wishbone register slave
// assumes channel, external clock and reset pins are asynchronous to clk
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`include "trig_defines.svh"

module trig_sequencer #(
	parameter int CHANNELS = 4,
	parameter int FILT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// logic under test
	input wire logic [CHANNELS-1:0] channel_in,
	input wire logic ext_clock_in,
	input wire logic reset_in,
	// time base and front panel
	input wire logic sweep_done,
	output logic sweep_trigger,
	output logic trigger_output_connector,
	output logic trigger_replica_trace,
	output logic [CHANNELS-1:0] display_channel,
	output logic [CHANNELS-1:0] ground_channel
);
	import trig_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [`CTL_W-1:0] control;
	logic [`FUNC_W-1:0] func_a;
	logic [`FUNC_W-1:0] func_b;
	logic [FILT_W-1:0] filter_cycles;
	logic [CHANNELS-1:0] display_on;
	logic [CHANNELS-1:0] ground_on;
	logic [3:0] error_code;
	logic trig_q;
	logic armed_q;
	logic wr;
	logic rd;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	function automatic logic has_edge_f(input logic [`FUNC_W-1:0] f);
		logic e;
		e = 1'b0;
		for (int i = 0; i < 2*CHANNELS; i++) begin
			e = e || (f[i*`TERM_W +: `TERM_W] == TERM_RISE)
				|| (f[i*`TERM_W +: `TERM_W] == TERM_FALL);
		end
		return e;
	endfunction : has_edge_f

	// edit write: bit 31 set clears the selected function
	// edit format: [4:3] channel, [5] column, [8:6] term, [9] or operator
	logic [1:0] ed_ch;
	logic ed_col;
	logic [2:0] ed_term;
	logic ed_or;
	logic ed_edge;
	logic sel_b;
	logic [`FUNC_W-1:0] sel_func;
	logic or_used_a;
	logic or_used_b;

	assign ed_ch = wb_dat_i[4:3];
	assign ed_col = wb_dat_i[5];
	assign ed_term = wb_dat_i[8:6];
	assign ed_or = wb_dat_i[9];
	assign ed_edge = (ed_term == TERM_RISE) || (ed_term == TERM_FALL);
	assign sel_b = control[`CTL_SEL_B];
	assign sel_func = sel_b ? func_b : func_a;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			control <= '0;
			filter_cycles <= '0;
			display_on <= '1;
			ground_on <= '0;
		end else if (wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				`OFS_CONTROL: begin
					// qualification refused while an edge term is stored
					if (wb_dat_i[`CTL_EXTQ] && !control[`CTL_EXTQ]
						&& (has_edge_f(func_a) || has_edge_f(func_b))) begin
						control <= {wb_dat_i[`CTL_W-1:`CTL_EXTQ+1], 1'b0,
							wb_dat_i[`CTL_EXTQ-1:0]};
					end else begin
						control <= wb_dat_i[`CTL_W-1:0];
					end
				end
				`OFS_FILTER: filter_cycles <= wb_dat_i[FILT_W-1:0];
				`OFS_CHANNEL: begin
					display_on <= wb_dat_i[CHANNELS-1:0];
					ground_on <= wb_dat_i[CHANNELS+7:8];
				end
				default: ;
			endcase
		end
	end

	// edits touch only the selected function; the stored one is kept
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			func_a <= '0;
			func_b <= '0;
			or_used_a <= 1'b0;
			or_used_b <= 1'b0;
			error_code <= `ERR_NONE;
		end else if (wr && wb_sel_i[0]) begin
			if (wb_adr_i == `OFS_FUNC_A) begin
				func_a <= wb_dat_i[`FUNC_W-1:0];
				or_used_a <= 1'b0;
			end else if (wb_adr_i == `OFS_FUNC_B) begin
				func_b <= wb_dat_i[`FUNC_W-1:0];
				or_used_b <= 1'b0;
			end else if (wb_adr_i == `OFS_STATUS) begin
				error_code <= `ERR_NONE;
			end else if (wb_adr_i == `OFS_CONTROL && wb_dat_i[`CTL_EXTQ]
				&& !control[`CTL_EXTQ]
				&& (has_edge_f(func_a) || has_edge_f(func_b))) begin
				error_code <= `ERR_EDGE_ON;
			end else if (wb_adr_i == `OFS_EDIT) begin
				if (wb_dat_i[31]) begin
					// clear selected function only
					if (sel_b) begin
						func_b <= '0;
						or_used_b <= 1'b0;
					end else begin
						func_a <= '0;
						or_used_a <= 1'b0;
					end
				end else if (ed_or) begin
					if (sel_b ? or_used_b : or_used_a) begin
						error_code <= `ERR_OR_FULL;
					end else if (sel_b) begin
						or_used_b <= 1'b1;
					end else begin
						or_used_a <= 1'b1;
					end
				end else if (ed_edge && control[`CTL_EXTQ]) begin
					error_code <= `ERR_EXTCLK_ON;
				end else if (sel_b) begin
					func_b[({ed_col, ed_ch}*`TERM_W) +: `TERM_W] <= ed_term;
				end else begin
					func_a[({ed_col, ed_ch}*`TERM_W) +: `TERM_W] <= ed_term;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= '0;
		end else if (rd) begin
			case (wb_adr_i)
				`OFS_CONTROL: wb_dat_o <= {{(32-`CTL_W){1'b0}}, control};
				`OFS_FUNC_A: wb_dat_o <= {{(32-`FUNC_W){1'b0}}, func_a};
				`OFS_FUNC_B: wb_dat_o <= {{(32-`FUNC_W){1'b0}}, func_b};
				`OFS_FILTER: wb_dat_o <= {{(32-FILT_W){1'b0}}, filter_cycles};
				`OFS_CHANNEL: wb_dat_o <= {{(24-CHANNELS){1'b0}}, ground_on,
					{(8-CHANNELS){1'b0}}, display_on};
				`OFS_STATUS: wb_dat_o <= {24'h0000_00, armed_q, trig_q, 2'h0, error_code};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers and edge detect
	logic [CHANNELS-1:0] ch_s1, ch_s2, ch_q;
	logic [2:0] xc_s;
	logic [1:0] rs_s;
	logic [CHANNELS-1:0] ch_level, ch_rise, ch_fall;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ch_s1 <= '0;
			ch_s2 <= '0;
			ch_q <= '0;
			xc_s <= '0;
			rs_s <= '0;
		end else begin
			ch_s1 <= channel_in;
			ch_s2 <= ch_s1;
			ch_q <= ch_s2;
			xc_s <= {xc_s[1:0], ext_clock_in};
			rs_s <= {rs_s[0], reset_in};
		end
	end

	// grounded channels see a constant low
	assign ch_level = ch_s2 & ~ground_on;
	assign ch_rise = ch_s2 & ~ch_q & ~ground_on;
	assign ch_fall = ~ch_s2 & ch_q & ~ground_on;

	////////////////////////////////////////////////////////////////////////////
	// recognisers and filters
	logic hit_a, hit_b, edge_a, edge_b;
	logic inhibit;
	logic ext_edge;
	logic extq;

	word_recognizer #(.CHANNELS(CHANNELS)) u_rec_a (
		.terms(func_a), .level(ch_level), .rise(ch_rise), .fall(ch_fall),
		.hit(hit_a), .has_edge(edge_a)
	);
	word_recognizer #(.CHANNELS(CHANNELS)) u_rec_b (
		.terms(func_b), .level(ch_level), .rise(ch_rise), .fall(ch_fall),
		.hit(hit_b), .has_edge(edge_b)
	);

	assign inhibit = rs_s[1];
	assign extq = control[`CTL_EXTQ];
	assign ext_edge = control[`CTL_SLOPE] ? (xc_s[1] && !xc_s[2])
		: (!xc_s[1] && xc_s[2]);

	logic [1:0] hit_v, edge_v, pass;
	logic [1:0][FILT_W-1:0] run_cnt;
	assign hit_v = {hit_b, hit_a};
	assign edge_v = {edge_b, edge_a};

	for (genvar f = 0; f < 2; f++) begin : g_filt
		logic filt_on;
		logic clean;
		assign filt_on = !edge_v[f] && !extq && (filter_cycles != '0);
		assign clean = hit_v[f] && !inhibit;
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				run_cnt[f] <= '0;
			end else if (!clean) begin
				run_cnt[f] <= '0;
			end else if (run_cnt[f] != '1) begin
				run_cnt[f] <= run_cnt[f] + 1'b1;
			end
		end
		// pass once the true interval has lasted the set delay
		assign pass[f] = clean && (!filt_on || run_cnt[f] >= filter_cycles - 1'b1)
			&& (!extq || ext_edge);
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer and output
	seq_state_t seq, next_seq;
	logic fire;

	always_comb begin
		next_seq = seq;
		fire = 1'b0;
		case (seq)
			SEQ_IDLE: if (pass[0] && !inhibit) next_seq = SEQ_ARMED;
			SEQ_ARMED: begin
				if (inhibit) begin
					next_seq = SEQ_IDLE;
				end else if (pass[1]) begin
					fire = 1'b1;
					next_seq = control[`CTL_GATE] ? SEQ_FIRED : SEQ_IDLE;
				end
			end
			SEQ_FIRED: begin
				fire = pass[1] || (hit_b && !inhibit && !extq);
				if (!fire) next_seq = SEQ_IDLE;
			end
			default: next_seq = SEQ_IDLE;
		endcase
		if (!control[`CTL_SEQ]) begin
			next_seq = SEQ_IDLE;
			fire = sel_b ? pass[1] : pass[0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seq <= SEQ_IDLE;
			trig_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			seq <= next_seq;
			trig_q <= fire;
			armed_q <= (next_seq == SEQ_ARMED);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sweep_trigger <= 1'b0;
			trigger_output_connector <= 1'b0;
			trigger_replica_trace <= 1'b0;
		end else begin
			sweep_trigger <= fire;
			trigger_output_connector <= fire;
			trigger_replica_trace <= (control[`CTL_VIEW] || display_on == '0)
				&& (extq ? xc_s[1] : fire);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display interleave
	logic [$clog2(`CHOP_CYC)-1:0] chop_cnt;
	logic [1:0] disp_idx;
	logic advance;

	assign advance = control[`CTL_ALT] ? sweep_done : (chop_cnt == '0);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chop_cnt <= '0;
		end else if (chop_cnt == '0) begin
			chop_cnt <= ($clog2(`CHOP_CYC))'(`CHOP_CYC - 1);
		end else begin
			chop_cnt <= chop_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			disp_idx <= '0;
			display_channel <= '0;
			ground_channel <= '0;
		end else begin
			if (advance) disp_idx <= disp_idx + 1'b1;
			// grounded traces stay displayed
			display_channel <= display_on & (CHANNELS'(1) << disp_idx);
			ground_channel <= ground_on;
		end
	end
endmodule : trig_sequencer

// ===== dv/trig_sequencer_checker.sv
// port-level assertions for the trigger sequencer
// assumes binding onto trig_sequencer, one clock domain
module trig_sequencer_checker #(
	parameter int CHANNELS = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// trigger side
	input wire logic reset_in,
	input wire logic sweep_trigger,
	input wire logic trigger_output_connector,
	input wire logic [CHANNELS-1:0] display_channel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_sweep_pair: assert property (sweep_trigger == trigger_output_connector)
		else $error("sweep and connector differ");
	// two sync flops plus the fire register fit in five cycles
	a_inhibit_quiet: assert property (reset_in [*5] |-> !trigger_output_connector)
		else $error("trigger while inhibited");
	a_trace_onehot: assert property ($onehot0(display_channel))
		else $error("more than one trace shown");
	a_reset_quiet: assert property ($rose(resetn) |-> !sweep_trigger && !wb_ack_o)
		else $error("outputs busy after reset");
	c_trig: cover property (trigger_output_connector);
	c_ack: cover property (wb_ack_o);
	c_inhibit: cover property (reset_in ##1 !reset_in);
endmodule : trig_sequencer_checker

// ===== dv/trig_host_model.sv
// logic under test and host time base around the trigger sequencer
// assumes bench requests change just after clk edges
module trig_host_model (
	// clock and sweep start
	input wire logic clk,
	input wire logic sweep_trigger,
	// bench requests
	input wire logic [3:0] want_chan,
	input wire logic want_inhibit,
	input wire logic ext_run,
	// toward the block
	output logic [3:0] channel_in,
	output logic reset_in,
	output logic ext_clock_in,
	output logic sweep_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int sweep_left;
	////////////////////////////////////////
	initial begin
		channel_in = 4'h0;
		reset_in = 1'b0;
		ext_clock_in = 1'b0;
		sweep_done = 1'b0;
		sweep_left = 0;
	end
	// link clock stands low outside frames, toggles every 40 ns, on falling edges of clk
	always #40 ext_clock_in = ext_run ? !ext_clock_in : 1'b0;
	always @(posedge clk) begin
		channel_in <= want_chan;
		reset_in <= want_inhibit;
	end
	// a sweep lasts twenty cycles, then the time base reports its end
	always @(posedge clk) begin
		sweep_done <= (sweep_left == 1);
		if (sweep_trigger && sweep_left == 0)
			sweep_left <= 20;
		else if (sweep_left != 0)
			sweep_left <= sweep_left - 1;
	end
endmodule : trig_host_model

// ===== dv/trig_sequencer_test.sv
// self-checking bench for the trigger sequencer over wishbone
// assumes the host model drives channels, inhibit and link clock
`include "trig_defines.svh"
module trig_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic resetn = 0;
	logic wb_cyc_i = 0;
	logic wb_stb_i = 0;
	logic wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] channel_in;
	logic ext_clock_in;
	logic reset_in;
	logic sweep_done;
	logic sweep_trigger;
	logic trigger_output_connector;
	logic trigger_replica_trace;
	logic [3:0] display_channel;
	logic [3:0] ground_channel;
	logic [3:0] want_chan = 4'h0;
	logic want_inhibit = 0;
	logic ext_run = 0;
	logic [31:0] q;
	int err_count = 0;
	int cmp_count = 0;
	int hits = 0;
	int vis = 0;
	always #5 clk = !clk;
	trig_sequencer #(.CHANNELS(4), .FILT_W(16)) i_trig_sequencer (
		.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_in(channel_in),
		.ext_clock_in(ext_clock_in), .reset_in(reset_in), .sweep_done(sweep_done),
		.sweep_trigger(sweep_trigger), .trigger_output_connector(trigger_output_connector),
		.trigger_replica_trace(trigger_replica_trace), .display_channel(display_channel),
		.ground_channel(ground_channel));
	trig_host_model i_trig_host_model (
		.clk(clk), .sweep_trigger(sweep_trigger), .want_chan(want_chan),
		.want_inhibit(want_inhibit), .ext_run(ext_run), .channel_in(channel_in),
		.reset_in(reset_in), .ext_clock_in(ext_clock_in), .sweep_done(sweep_done));
	////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask : chk
	// classic cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		chk("ack", 1, n < 20);
	endtask : wb
	task automatic chan(input logic [3:0] c);
		@(posedge clk);
		want_chan <= c;
	endtask : chan
	// counts trigger and replica cycles over the window
	task automatic trig(input int lim, input logic exp);
		hits = 0;
		vis = 0;
		repeat (lim) begin
			@(posedge clk);
			if (trigger_output_connector === 1'b1)
				hits++;
			if (trigger_replica_trace === 1'b1)
				vis++;
		end
		chk("trigger", exp, hits != 0);
	endtask : trig
	////////////////////////////////////////
	initial begin
		#300000;
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		wb(0, `OFS_CONTROL, 0);
		chk("control", 0, q);
		wb(0, 8'h1C, 0);
		chk("unmapped", 0, q);
		wb(1, `OFS_FUNC_A, 32'h0000_0001);
		trig(10, 0);
		chan(4'h1);
		trig(10, 1);
		chk("replica", 0, vis);
		want_inhibit <= 1'b1;
		repeat (5) @(posedge clk);
		trig(10, 0);
		want_inhibit <= 1'b0;
		trig(10, 1);
		chan(4'h0);
		wb(1, `OFS_CONTROL, 32'h0000_0001);
		wb(1, `OFS_EDIT, 32'h8000_0000);
		chan(4'h1);
		trig(10, 0);
		wb(0, `OFS_FUNC_A, 0);
		chk("func_a", 32'h0000_0001, q);
		chan(4'h0);
		wb(1, `OFS_FUNC_B, 32'h0000_0008);
		wb(1, `OFS_CONTROL, 32'h0000_0002);
		chan(4'h2);
		trig(12, 0);
		chan(4'h1);
		repeat (8) @(posedge clk);
		wb(0, `OFS_STATUS, 0);
		chk("armed", 1, q[7]);
		want_inhibit <= 1'b1;
		repeat (8) @(posedge clk);
		// drop function a before release, or it re-arms at once
		chan(4'h0);
		repeat (4) @(posedge clk);
		want_inhibit <= 1'b0;
		repeat (6) @(posedge clk);
		wb(0, `OFS_STATUS, 0);
		chk("armed", 0, q[7]);
		chan(4'h2);
		trig(12, 0);
		chan(4'h1);
		repeat (8) @(posedge clk);
		chan(4'h2);
		trig(12, 1);
		chk("pulse", 1, hits);
		wb(0, `OFS_STATUS, 0);
		chk("armed", 0, q[7]);
		chan(4'h0);
		wb(1, `OFS_CONTROL, 32'h0000_0012);
		chan(4'h1);
		repeat (8) @(posedge clk);
		chan(4'h2);
		trig(12, 1);
		chk("gate", 1, hits > 4);
		chan(4'h0);
		wb(1, `OFS_CONTROL, 0);
		wb(1, `OFS_FILTER, 32'h0000_0010);
		chan(4'h1);
		trig(8, 0);
		chan(4'h0);
		trig(20, 0);
		chan(4'h1);
		trig(30, 1);
		chan(4'h0);
		wb(1, `OFS_FUNC_A, 32'h0000_0003);
		chan(4'h1);
		trig(10, 1);
		wb(1, `OFS_CONTROL, 32'h0000_0004);
		wb(0, `OFS_STATUS, 0);
		chk("error", 4'hA, q[3:0]);
		wb(0, `OFS_CONTROL, 0);
		chk("qualify", 0, q[2]);
		wb(1, `OFS_STATUS, 0);
		chan(4'h0);
		wb(1, `OFS_FUNC_A, 32'h0000_0001);
		wb(1, `OFS_FILTER, 0);
		wb(1, `OFS_CONTROL, 32'h0000_002C);
		chan(4'h1);
		trig(10, 0);
		chk("replica", 0, vis);
		ext_run <= 1'b1;
		trig(40, 1);
		chk("replica", 1, vis > 10);
		wb(1, `OFS_EDIT, 32'h0000_00C0);
		wb(0, `OFS_STATUS, 0);
		chk("error", 4'hB, q[3:0]);
		wb(0, `OFS_FUNC_A, 0);
		chk("func_a", 32'h0000_0001, q);
		wb(1, `OFS_STATUS, 0);
		ext_run <= 1'b0;
		wb(1, `OFS_CONTROL, 0);
		wb(1, `OFS_EDIT, 32'h8000_0000);
		wb(1, `OFS_EDIT, 32'h0000_0048);
		wb(0, `OFS_FUNC_A, 0);
		chk("func_a", 32'h0000_0008, q);
		wb(1, `OFS_EDIT, 32'h0000_0200);
		wb(1, `OFS_EDIT, 32'h0000_0200);
		wb(0, `OFS_STATUS, 0);
		chk("error", 4'h7, q[3:0]);
		wb(1, `OFS_CHANNEL, 32'h0000_020F);
		chan(4'h2);
		trig(10, 0);
		chk("ground", 4'h2, ground_channel);
		wb(1, `OFS_CHANNEL, 0);
		trig(10, 1);
		chk("replica", hits, vis);
		wb(1, `OFS_CHANNEL, 32'h0000_000F);
		chan(4'h0);
		repeat (4) @(posedge clk);
		q = display_channel;
		repeat (`CHOP_CYC) @(posedge clk);
		chk("trace", 1, q[3:0] != 4'h0);
		chk("trace", {q[2:0], q[3]}, display_channel);
		wb(1, `OFS_FUNC_A, 32'h0000_0003);
		wb(1, `OFS_CONTROL, 32'h0000_0040);
		repeat (2) @(posedge clk);
		q = display_channel;
		repeat (150) @(posedge clk);
		chk("trace", q, display_channel);
		chan(4'h1);
		trig(40, 1);
		chk("trace", {q[2:0], q[3]}, display_channel);
		end_of_test();
	end
endmodule : trig_sequencer_test
bind trig_sequencer trig_sequencer_checker #(.CHANNELS(CHANNELS)) i_trig_sequencer_checker (
	.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_in(reset_in),
	.sweep_trigger(sweep_trigger), .trigger_output_connector(trigger_output_connector),
	.display_channel(display_channel));
